// ### logic/nco_cal_pkg.sv
// Constants for the oscillator preset, init and sysref calibration register group
package nco_cal_pkg;
   // ---------------------------------------------------------------
   // Byte addresses on the serial port
   // ---------------------------------------------------------------
   localparam logic [14:0] OFS_PHASE_P2 = 15'h0254;
   localparam logic [14:0] OFS_FREQ_P3 = 15'h0258;
   localparam logic [14:0] OFS_PHASE_P3 = 15'h025c;
   localparam logic [14:0] OFS_INIT = 15'h0270;
   localparam logic [14:0] OFS_REVISION = 15'h0297;
   localparam logic [14:0] OFS_RAIL = 15'h02a2;
   localparam logic [14:0] OFS_CAL_EN = 15'h02b0;
   localparam logic [14:0] OFS_CAL_STATUS = 15'h02b2;
   // ---------------------------------------------------------------
   // Fields and reset values
   // ---------------------------------------------------------------
   localparam int BIT_INIT_DONE = 0;
   localparam int BIT_DIG_RAIL = 5;
   localparam int BIT_CLK_RAIL = 4;
   localparam int BIT_CAL_EN = 0;
   localparam int BIT_CAL_DONE = 17;
   localparam int REV_MSB = 4;
   localparam logic [15:0] RST_PHASE = 16'h0000;
   localparam logic [31:0] RST_FREQ = 32'hc0000000;
   localparam logic [7:0] RST_RAIL = 8'h00;
   localparam logic [7:0] RST_CAL_EN = 8'h00;
   // Arbitrary neutral revision value
   localparam logic [4:0] RST_REVISION = 5'h15;
   // ---------------------------------------------------------------
   // Serial frame and timing
   // ---------------------------------------------------------------
   localparam logic [3:0] CMD_LAST_BIT = 4'hf;
   localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
   localparam int CMD_READ_BIT = 14;
   localparam int CLK_PERIOD_NS = 50;
   localparam int INIT_TIME_NS = 1000;
   localparam logic [5:0] INIT_CYCLES = 6'((INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : nco_cal_pkg

// ### logic/pin_sync.sv
// Two-stage synchroniser for one pin input
`timescale 1ns/1ps
module pin_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic pin,
   output logic level
);
   logic meta_r;
   logic sync_r;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         meta_r <= RST_VAL;
         sync_r <= RST_VAL;
      end else begin
         meta_r <= pin;
         sync_r <= meta_r;
      end
   end

   assign level = sync_r;
endmodule : pin_sync

// ### logic/adc_nco_init_sysref_cal_regs.sv
// Serial-port register group: channel B presets, init status, revision, rail noise, sysref calibration
`timescale 1ns/1ps
module adc_nco_init_sysref_cal_regs (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic spi_sclk,
   input wire logic spi_csb_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe_n,
   input wire logic des_mode,
   input wire logic [16:0] manual_tad,
   input wire logic cal_finished,
   input wire logic [16:0] cal_tad,
   output logic [15:0] nco_phase_chb_p2,
   output logic [31:0] nco_freq_chb_p3,
   output logic [15:0] nco_phase_chb_p3,
   output logic digital_rail_noise_suppress_en,
   output logic clock_rail_noise_suppress_en,
   output logic sysref_cal_start,
   output logic sysref_cal_done,
   output logic [16:0] aperture_delay,
   output logic init_done
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic sclk_s;
   logic csb_s;
   logic sdi_s;

   pin_sync #(.RST_VAL(1'b0)) u_sync_sclk (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin(spi_sclk), .level(sclk_s));
   pin_sync #(.RST_VAL(1'b1)) u_sync_csb (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin(spi_csb_n), .level(csb_s));
   pin_sync #(.RST_VAL(1'b0)) u_sync_sdi (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin(spi_sdi), .level(sdi_s));

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [15:0] phase_p2_r;
   logic [31:0] freq_p3_r;
   logic [15:0] phase_p3_r;
   logic [7:0] rev_r;
   logic [7:0] rail_r;
   logic [7:0] cal_en_r;
   logic cal_en_prev_r;
   logic done_r;
   logic [16:0] tad_r;
   logic [5:0] init_cnt_r;
   logic init_done_r;
   logic sclk_d_r;
   logic in_data_r;
   logic [3:0] cnt_r;
   logic [14:0] cmd_r;
   logic [14:0] addr_r;
   logic rd_r;
   logic [6:0] wr_sh_r;
   logic [7:0] rd_sh_r;
   logic sdo_r;
   logic oe_n_r;

   // ---------------------------------------------------------------
   // Frame decode
   // ---------------------------------------------------------------
   wire active = ~csb_s;
   wire rise = active & sclk_s & ~sclk_d_r;
   wire fall = active & ~sclk_s & sclk_d_r;
   wire cmd_last = rise & ~in_data_r & (cnt_r == nco_cal_pkg::CMD_LAST_BIT);
   wire byte_last = rise & in_data_r & (cnt_r == nco_cal_pkg::BYTE_LAST_BIT);
   wire [14:0] cmd_addr = {cmd_r[13:0], sdi_s};
   wire [14:0] next_addr = 15'(addr_r + 15'h0001);
   wire [14:0] rd_addr = cmd_last ? cmd_addr : next_addr;
   wire [7:0] wr_byte = {wr_sh_r, sdi_s};
   wire wr_en = byte_last & ~rd_r;
   wire [14:0] freq_rel = 15'(addr_r - nco_cal_pkg::OFS_FREQ_P3);
   wire we_p2_lo = wr_en & (addr_r == nco_cal_pkg::OFS_PHASE_P2);
   wire we_p2_hi = wr_en & (addr_r == 15'(nco_cal_pkg::OFS_PHASE_P2 + 15'h1));
   wire we_freq = wr_en & (freq_rel[14:2] == 13'h0000);
   wire we_p3_lo = wr_en & (addr_r == nco_cal_pkg::OFS_PHASE_P3);
   wire we_p3_hi = wr_en & (addr_r == 15'(nco_cal_pkg::OFS_PHASE_P3 + 15'h1));
   wire we_rev = wr_en & (addr_r == nco_cal_pkg::OFS_REVISION);
   wire we_rail = wr_en & (addr_r == nco_cal_pkg::OFS_RAIL);
   wire we_cal = wr_en & (addr_r == nco_cal_pkg::OFS_CAL_EN);
   wire cal_start = cal_en_r[nco_cal_pkg::BIT_CAL_EN] & ~cal_en_prev_r;
   // Old done hidden in the start cycle, before the restart clears it
   wire done_vis = cal_en_r[nco_cal_pkg::BIT_CAL_EN] & done_r & ~cal_start;
   wire [23:0] status_word = {6'h00, done_vis, tad_r};

   // ---------------------------------------------------------------
   // Read byte selection
   // ---------------------------------------------------------------
   logic [7:0] rd_byte;
   always_comb begin
      case (rd_addr)
         nco_cal_pkg::OFS_PHASE_P2: rd_byte = phase_p2_r[7:0];
         15'(nco_cal_pkg::OFS_PHASE_P2 + 15'h1): rd_byte = phase_p2_r[15:8];
         nco_cal_pkg::OFS_FREQ_P3: rd_byte = freq_p3_r[7:0];
         15'(nco_cal_pkg::OFS_FREQ_P3 + 15'h1): rd_byte = freq_p3_r[15:8];
         15'(nco_cal_pkg::OFS_FREQ_P3 + 15'h2): rd_byte = freq_p3_r[23:16];
         15'(nco_cal_pkg::OFS_FREQ_P3 + 15'h3): rd_byte = freq_p3_r[31:24];
         nco_cal_pkg::OFS_PHASE_P3: rd_byte = phase_p3_r[7:0];
         15'(nco_cal_pkg::OFS_PHASE_P3 + 15'h1): rd_byte = phase_p3_r[15:8];
         nco_cal_pkg::OFS_INIT: rd_byte = {7'h00, init_done_r};
         nco_cal_pkg::OFS_REVISION: rd_byte = rev_r;
         nco_cal_pkg::OFS_RAIL: rd_byte = rail_r;
         nco_cal_pkg::OFS_CAL_EN: rd_byte = cal_en_r;
         nco_cal_pkg::OFS_CAL_STATUS: rd_byte = status_word[7:0];
         15'(nco_cal_pkg::OFS_CAL_STATUS + 15'h1): rd_byte = status_word[15:8];
         15'(nco_cal_pkg::OFS_CAL_STATUS + 15'h2): rd_byte = status_word[23:16];
         default: rd_byte = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // Serial port engine
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !active) begin
         in_data_r <= 1'b0;
         cnt_r <= 4'h0;
         cmd_r <= 15'h0000;
         addr_r <= 15'h0000;
         rd_r <= 1'b0;
         wr_sh_r <= 7'h00;
         rd_sh_r <= 8'h00;
         sdo_r <= 1'b0;
         oe_n_r <= 1'b1;
      end else begin
         if (rise) begin
            cnt_r <= (cmd_last || byte_last) ? 4'h0 : 4'(cnt_r + 4'h1);
            cmd_r <= cmd_addr;
            wr_sh_r <= wr_byte[6:0];
         end
         if (cmd_last) begin
            in_data_r <= 1'b1;
            rd_r <= cmd_r[nco_cal_pkg::CMD_READ_BIT];
            addr_r <= cmd_addr;
         end
         if (byte_last) begin
            addr_r <= next_addr;
         end
         if (cmd_last || byte_last) begin
            rd_sh_r <= rd_byte;
         end else if (fall && in_data_r && rd_r) begin
            sdo_r <= rd_sh_r[7];
            oe_n_r <= 1'b0;
            rd_sh_r <= {rd_sh_r[6:0], 1'b0};
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         phase_p2_r <= nco_cal_pkg::RST_PHASE;
         freq_p3_r <= nco_cal_pkg::RST_FREQ;
         phase_p3_r <= nco_cal_pkg::RST_PHASE;
         rev_r <= {3'h0, nco_cal_pkg::RST_REVISION};
         rail_r <= nco_cal_pkg::RST_RAIL;
         cal_en_r <= nco_cal_pkg::RST_CAL_EN;
      end else begin
         if (we_p2_lo) phase_p2_r[7:0] <= wr_byte;
         if (we_p2_hi) phase_p2_r[15:8] <= wr_byte;
         if (we_freq) freq_p3_r[{freq_rel[1:0], 3'b000} +: 8] <= wr_byte;
         if (we_p3_lo) phase_p3_r[7:0] <= wr_byte;
         if (we_p3_hi) phase_p3_r[15:8] <= wr_byte;
         if (we_rev) rev_r <= wr_byte;
         if (we_rail) rail_r <= wr_byte;
         if (we_cal) cal_en_r <= wr_byte;
      end
   end

   // ---------------------------------------------------------------
   // Init sequencing and calibration control
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         init_cnt_r <= 6'h00;
         init_done_r <= 1'b0;
         sclk_d_r <= 1'b0;
         cal_en_prev_r <= 1'b0;
         done_r <= 1'b0;
         tad_r <= 17'h00000;
      end else begin
         if (init_cnt_r != nco_cal_pkg::INIT_CYCLES) init_cnt_r <= 6'(init_cnt_r + 6'h01);
         init_done_r <= (init_cnt_r == nco_cal_pkg::INIT_CYCLES);
         cal_en_prev_r <= cal_en_r[nco_cal_pkg::BIT_CAL_EN];
         sclk_d_r <= sclk_s;
         if (cal_finished && cal_en_r[nco_cal_pkg::BIT_CAL_EN]) begin
            done_r <= 1'b1;
            tad_r <= cal_tad;
         end else if (cal_start) begin
            done_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         nco_phase_chb_p2 <= 16'h0000;
         nco_freq_chb_p3 <= 32'h00000000;
         nco_phase_chb_p3 <= 16'h0000;
         digital_rail_noise_suppress_en <= 1'b0;
         clock_rail_noise_suppress_en <= 1'b0;
         sysref_cal_start <= 1'b0;
         sysref_cal_done <= 1'b0;
         aperture_delay <= 17'h00000;
      end else begin
         nco_phase_chb_p2 <= des_mode ? 16'h0000 : phase_p2_r;
         nco_freq_chb_p3 <= des_mode ? 32'h00000000 : freq_p3_r;
         nco_phase_chb_p3 <= des_mode ? 16'h0000 : phase_p3_r;
         digital_rail_noise_suppress_en <= rail_r[nco_cal_pkg::BIT_DIG_RAIL];
         clock_rail_noise_suppress_en <= rail_r[nco_cal_pkg::BIT_CLK_RAIL];
         sysref_cal_start <= cal_start;
         sysref_cal_done <= done_vis;
         aperture_delay <= cal_en_r[nco_cal_pkg::BIT_CAL_EN] ? tad_r : manual_tad;
      end
   end

   assign spi_sdo = sdo_r;
   assign spi_sdo_oe_n = oe_n_r;
   assign init_done = init_done_r;
endmodule : adc_nco_init_sysref_cal_regs

// ### test/spi_host_model.sv
// Serial host model driving the configuration port frames
`timescale 1ns/1ps
module spi_host_model (
   input wire logic ref_clk,
   input wire logic init_done,
   input wire logic spi_sdo,
   output logic spi_sclk,
   output logic spi_csb_n,
   output logic spi_sdi
);
   initial begin
      spi_sclk = 1'b0;
      spi_csb_n = 1'b1;
      spi_sdi = 1'b0;
   end
   task automatic half();
      repeat (5) @(negedge ref_clk);
   endtask : half
   task automatic xfer(input logic rd, input logic [14:0] adr, input logic [7:0] wd, output logic [7:0] rdat);
      logic [23:0] frame;
      frame = {rd, adr, wd};
      rdat = 8'h00;
      while (init_done !== 1'b1) @(negedge ref_clk);
      spi_csb_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spi_sdi = frame[i];
         half();
         if (i < 8) rdat[i] = spi_sdo;
         spi_sclk = 1'b1;
         half();
         spi_sclk = 1'b0;
      end
      half();
      spi_csb_n = 1'b1;
      // Released line carries no stale bit
      spi_sdi = ~spi_sdi;
      half();
   endtask : xfer
endmodule : spi_host_model

// ### test/adc_nco_init_sysref_cal_regs_asserts.sv
// Port checker for the register group
`timescale 1ns/1ps
module adc_nco_init_sysref_cal_regs_asserts (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic spi_csb_n,
   input wire logic spi_sdo_oe_n,
   input wire logic des_mode,
   input wire logic cal_finished,
   input wire logic [16:0] cal_tad,
   input wire logic [15:0] nco_phase_chb_p2,
   input wire logic [31:0] nco_freq_chb_p3,
   input wire logic [15:0] nco_phase_chb_p3,
   input wire logic digital_rail_noise_suppress_en,
   input wire logic clock_rail_noise_suppress_en,
   input wire logic sysref_cal_start,
   input wire logic sysref_cal_done,
   input wire logic [16:0] aperture_delay,
   input wire logic init_done
);
   logic [5:0] up_r;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   always_ff @(posedge ref_clk) begin
      if (sys_rst) up_r <= 6'h00;
      else if (up_r != 6'h3f) up_r <= up_r + 6'h01;
   end
   rst_values_a: assert property (disable iff (1'b0) sys_rst |=> spi_sdo_oe_n && !init_done
      && !sysref_cal_start && nco_phase_chb_p2 == 16'h0000 && nco_phase_chb_p3 == 16'h0000) else $error("reset value");
   freq_reset_a: assert property ($fell(sys_rst) && !des_mode |-> ##[1:2] nco_freq_chb_p3 == 32'hc0000000)
      else $error("freq reset");
   init_early_a: assert property (init_done |-> up_r >= 6'h12) else $error("init early");
   init_late_a: assert property (up_r >= 6'h18 |-> init_done) else $error("init late");
   des_zero_a: assert property (des_mode ##1 des_mode |-> {nco_phase_chb_p2, nco_freq_chb_p3, nco_phase_chb_p3} == 64'h0)
      else $error("des outputs");
   quiet_port_a: assert property (spi_csb_n [*6] |-> $stable(digital_rail_noise_suppress_en)
      && $stable(clock_rail_noise_suppress_en) && !sysref_cal_start) else $error("change without frame");
   start_pulse_a: assert property (sysref_cal_start |=> !sysref_cal_start) else $error("start pulse");
   done_cause_a: assert property ($rose(sysref_cal_done) |-> $past(cal_finished, 2)) else $error("done cause");
   cal_delay_a: assert property ($rose(sysref_cal_done) |-> aperture_delay == $past(cal_tad, 2))
      else $error("cal delay");
   cover property ($rose(sysref_cal_done));
   cover property (sysref_cal_start);
   cover property (des_mode ##1 des_mode);
endmodule : adc_nco_init_sysref_cal_regs_asserts
bind adc_nco_init_sysref_cal_regs adc_nco_init_sysref_cal_regs_asserts chk_i (
   .ref_clk(ref_clk),
   .sys_rst(sys_rst),
   .spi_csb_n(spi_csb_n),
   .spi_sdo_oe_n(spi_sdo_oe_n),
   .des_mode(des_mode),
   .cal_finished(cal_finished),
   .cal_tad(cal_tad),
   .nco_phase_chb_p2(nco_phase_chb_p2),
   .nco_freq_chb_p3(nco_freq_chb_p3),
   .nco_phase_chb_p3(nco_phase_chb_p3),
   .digital_rail_noise_suppress_en(digital_rail_noise_suppress_en),
   .clock_rail_noise_suppress_en(clock_rail_noise_suppress_en),
   .sysref_cal_start(sysref_cal_start),
   .sysref_cal_done(sysref_cal_done),
   .aperture_delay(aperture_delay),
   .init_done(init_done)
);

// ### test/adc_nco_init_sysref_cal_regs_bench.sv
// Self-checking bench for the register group
`timescale 1ns/1ps
module adc_nco_init_sysref_cal_regs_bench;
   logic ref_clk = 1'b0, sys_rst = 1'b1, tog = 1'b0, des_mode = 1'b0, cal_finished = 1'b0;
   logic spi_sclk, spi_csb_n, spi_sdi, spi_sdo, spi_sdo_oe_n, sdo_line, sysref_cal_start, sysref_cal_done, init_done;
   logic digital_rail_noise_suppress_en, clock_rail_noise_suppress_en;
   logic [16:0] manual_tad = 17'h00000, cal_tad = 17'h00000, tad_exp, aperture_delay;
   logic [15:0] nco_phase_chb_p2, nco_phase_chb_p3;
   logic [31:0] nco_freq_chb_p3;
   logic [7:0] d;
   logic [7:0] mdl [int];
   int adr [$] = '{12'h254, 12'h255, 12'h258, 12'h259, 12'h25a, 12'h25b, 12'h25c, 12'h25d, 12'h270, 12'h297,
      12'h2a2, 12'h2b0, 12'h2b1, 12'h2b2, 12'h2b3, 12'h2b4, 12'h300};
   int mismatches = 0, checks_done = 0, starts = 0;
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) tog <= ~tog;
   always @(posedge ref_clk) if (sysref_cal_start === 1'b1) starts <= starts + 1;
   // Undriven data line changes every cycle
   assign sdo_line = (spi_sdo_oe_n === 1'b0) ? spi_sdo : tog;
   adc_nco_init_sysref_cal_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk),
      .spi_csb_n(spi_csb_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n),
      .des_mode(des_mode), .manual_tad(manual_tad), .cal_finished(cal_finished), .cal_tad(cal_tad),
      .nco_phase_chb_p2(nco_phase_chb_p2), .nco_freq_chb_p3(nco_freq_chb_p3), .nco_phase_chb_p3(nco_phase_chb_p3),
      .digital_rail_noise_suppress_en(digital_rail_noise_suppress_en),
      .clock_rail_noise_suppress_en(clock_rail_noise_suppress_en), .sysref_cal_start(sysref_cal_start),
      .sysref_cal_done(sysref_cal_done), .aperture_delay(aperture_delay), .init_done(init_done));
   spi_host_model host (.ref_clk, .init_done, .spi_sdo(sdo_line), .spi_sclk, .spi_csb_n, .spi_sdi);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic out_chk();
      logic [63:0] n;
      n = des_mode ? 64'h0 : {mdl[12'h25d], mdl[12'h25c], mdl[12'h25b], mdl[12'h25a], mdl[12'h259], mdl[12'h258],
         mdl[12'h255], mdl[12'h254]};
      chk(32'(nco_phase_chb_p2), 32'(n[15:0]));
      chk(nco_freq_chb_p3, n[47:16]);
      chk(32'(nco_phase_chb_p3), 32'(n[63:48]));
      chk(32'({digital_rail_noise_suppress_en, clock_rail_noise_suppress_en}), 32'(mdl[12'h2a2][5:4]));
   endtask : out_chk
   task automatic wr(input int a, input logic [7:0] v);
      logic [7:0] unused;
      host.xfer(1'b0, 15'(a), v, unused);
      if (mdl.exists(a) && a != 12'h270 && a < 12'h2b2) mdl[a] = v;
   endtask : wr
   task automatic rd_chk(input int a);
      logic [7:0] v;
      host.xfer(1'b1, 15'(a), 8'h00, v);
      chk(32'(v), 32'(mdl.exists(a) ? mdl[a] : 8'h00));
   endtask : rd_chk
   initial begin
      #2ms;
      mismatches++;
      $display("watchdog expired");
      stop_test();
   end
   initial begin
      void'($urandom(79193));
      foreach (adr[i]) mdl[adr[i]] = 8'h00;
      mdl.delete(12'h2b1);
      mdl.delete(12'h300);
      mdl[12'h25b] = 8'hc0;
      mdl[12'h270] = 8'h01;
      mdl[12'h297] = {3'h0, nco_cal_pkg::RST_REVISION};
      repeat (3) @(negedge ref_clk);
      sys_rst = 1'b0;
      foreach (adr[i]) rd_chk(adr[i]);
      out_chk();
      $display("test reset values done");
      repeat (2) begin
         foreach (adr[i]) begin
            d = 8'($urandom);
            if (adr[i] == 12'h2b0) d[0] = 1'b0;
            wr(adr[i], d);
            out_chk();
         end
         foreach (adr[i]) rd_chk(adr[i]);
      end
      chk(starts, 0);
      $display("test random access done");
      des_mode = 1'b1;
      wr(12'h25a, 8'($urandom));
      out_chk();
      rd_chk(12'h25a);
      des_mode = 1'b0;
      repeat (3) @(negedge ref_clk);
      out_chk();
      $display("test interleaved mode done");
      manual_tad = 17'($urandom);
      repeat (3) @(negedge ref_clk);
      chk(32'(aperture_delay), 32'(manual_tad));
      $display("test manual delay done");
      wr(12'h2b1, 8'h05);
      wr(12'h2b0, 8'h01); // Converter calibration idle here
      chk(starts, 1);
      chk(32'(sysref_cal_done), 32'h0);
      tad_exp = 17'($urandom);
      cal_tad = tad_exp;
      cal_finished = 1'b1;
      @(negedge ref_clk) cal_finished = 1'b0;
      manual_tad = ~manual_tad;
      repeat (4) @(negedge ref_clk);
      chk(32'(sysref_cal_done), 32'h1);
      chk(32'(aperture_delay), 32'(tad_exp));
      mdl[12'h2b2] = tad_exp[7:0];
      mdl[12'h2b3] = tad_exp[15:8];
      mdl[12'h2b4] = {6'h00, 1'b1, tad_exp[16]};
      for (int i = 13; i < 16; i++) rd_chk(adr[i]);
      wr(12'h2b0, 8'h00);
      repeat (3) @(negedge ref_clk);
      chk(starts, 1);
      chk(32'(sysref_cal_done), 32'h0);
      chk(32'(aperture_delay), 32'(manual_tad));
      mdl[12'h2b4][1] = 1'b0;
      rd_chk(12'h2b4);
      $display("test calibration done");
      stop_test();
   end
endmodule : adc_nco_init_sysref_cal_regs_bench
